// ===== hw/dwscl_params.svh
// constants for the dual wiper serial command logic
`ifndef DWSCL_PARAMS_SVH
`define DWSCL_PARAMS_SVH
`define DWSCL_CLK_MHZ        125
`define DWSCL_SAVE_MS        25
`define DWSCL_SAVE_CYCLES    (`DWSCL_SAVE_MS * `DWSCL_CLK_MHZ * 1000)
`define DWSCL_WORD_BITS      16
`define DWSCL_MIDSCALE       8'h80
`define DWSCL_ZERO           8'h00
`define DWSCL_ONES           8'hff
`define DWSCL_CMD_MSB        15
`define DWSCL_CMD_LSB        12
`define DWSCL_ADR_MSB        11
`define DWSCL_ADR_LSB        8
`define DWSCL_DAT_MSB        7
`define DWSCL_DAT_LSB        0
`endif

// ===== hw/dwscl_pkg.sv
// types for the dual wiper serial command logic
package dwscl_pkg;
   typedef enum logic [3:0]
   {
      DWSCL_NOP      = 4'h0,
      DWSCL_RESTORE1 = 4'h1,
      DWSCL_SAVE     = 4'h2,
      DWSCL_SAVEDATA = 4'h3,
      DWSCL_SHR1     = 4'h4,
      DWSCL_SHRALL   = 4'h5,
      DWSCL_DEC1     = 4'h6,
      DWSCL_DECALL   = 4'h7,
      DWSCL_RESTORE  = 4'h8,
      DWSCL_READNV   = 4'h9,
      DWSCL_READW    = 4'ha,
      DWSCL_LOAD     = 4'hb,
      DWSCL_INC1     = 4'hc,
      DWSCL_INCALL   = 4'hd,
      DWSCL_SHL1     = 4'he,
      DWSCL_SHLALL   = 4'hf
   } dwscl_cmd_type;
   typedef struct packed
   {
      logic [3:0] cmd;
      logic [3:0] adr;
      logic [7:0] dat;
   } dwscl_word_type;
   typedef enum logic [1:0]
   {
      DWSCL_POWERUP = 2'b00,
      DWSCL_IDLE    = 2'b01,
      DWSCL_BUSY    = 2'b10
   } dwscl_state_type;
endpackage

// ===== hw/dwscl_top.sv
// serial command logic of a dual nonvolatile wiper controller
`timescale 1ns/1ps
`include "dwscl_params.svh"
// Operation
// - wiper code drives terminal position directly
// - save lasts 25 ms, shifter locked
// - ready output high when save done
// - command 11 loads data into wiper
// - command 2 copies wiper into store
// - power-on reloads wipers from store, midscale default
// - preset low forces midscale, rise reloads, both ignored while a save runs
// - 0xB040 loads 0x40 into first wiper
// - output returns previous word while shifting
// - inc/dec/shift repeats on later strobes
// - write protect blocks wiper loads, steps, shifts and saves, not restores
// - 16-bit words, most significant bit first
// - execute only when chip select rises
// - nop enters minimum power state
// - accept only multiples of 16 bits
// - non-multiple of 16 resets bit counter
// - bare strobe repeats previous inc/dec/shift command
// - serial output off while deselected
// - command picks operation, address picks target
// - sample input on serial clock rising edge
// - command, address, data field layout
// - output delays input by 16 clocks
// - ready marks 2,3,8 and preset
module dwscl_top
   import dwscl_pkg::*;
#(
   parameter int SAVE_CYCLES = `DWSCL_SAVE_CYCLES
)
(
   input  wire logic       CLOCK,          // system clock, 125 MHz
   input  wire logic       RESET_N,        // asynchronous reset, power-on
   input  wire logic       SCLK,           // serial clock from master
   input  wire logic       SDI,            // serial data in
   input  wire logic       CS_N,           // chip select
   input  wire logic       WP_N,           // write protect
   input  wire logic       PRESET_N,       // hardware_preset_input
   output logic            SDO_OUT,        // open-drain data, always 0
   output logic            SDO_OE_N,       // low while pulling sdo low
   output logic            READY,          // save or reload completed
   output logic            LOW_POWER,      // minimum power state after nop
   output logic [7:0]      FIRST_WIPER,    // first_wiper_terminal code
   output logic [7:0]      SECOND_WIPER,   // second_wiper_terminal code
   output logic [7:0]      STORE0,         // nonvolatile_setting_store 0
   output logic [7:0]      STORE1          // nonvolatile_setting_store 1
);
   logic [2:0]       sclk_sync;
   logic [2:0]       cs_sync;
   logic [1:0]       sdi_sync;
   logic [1:0]       wp_sync;
   logic [2:0]       pr_sync;
   logic             sclk_rise;
   logic             sclk_fall;
   logic             cs_rise;
   logic             pr_rise;
   logic [15:0]      shift;
   logic [5:0]       bits;
   logic [7:0]       wiper [2];
   logic [7:0]       store [16];
   dwscl_word_type   last;
   logic             repeat_ok;
   dwscl_state_type  state;
   logic [31:0]      busy_cnt;
   logic             sdo_bit;
   dwscl_word_type   w;
   dwscl_word_type   exec;
   logic             do_exec;

   // clamp arithmetic helpers for the wiper steps
   function automatic logic [7:0] step_up(input logic [7:0] v);
      step_up = (v == `DWSCL_ONES) ? v : v + 8'h01;
   endfunction
   function automatic logic [7:0] step_dn(input logic [7:0] v);
      step_dn = (v == `DWSCL_ZERO) ? v : v - 8'h01;
   endfunction
   function automatic logic [7:0] shl(input logic [7:0] v);
      shl = v[7] ? `DWSCL_ONES : {v[6:0], 1'b1};
   endfunction
   function automatic logic is_repeatable(input logic [3:0] c);
      is_repeatable = (c >= 4'h4 && c <= 4'h7) || (c >= 4'hc);
   endfunction

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         sclk_sync <= 3'h0;
         cs_sync   <= 3'h7;
         sdi_sync  <= 2'h0;
         wp_sync   <= 2'h3;
         pr_sync   <= 3'h7;
      end
      else
      begin
         sclk_sync <= {sclk_sync[1:0], SCLK};
         cs_sync   <= {cs_sync[1:0], CS_N};
         sdi_sync  <= {sdi_sync[0], SDI};
         wp_sync   <= {wp_sync[0], WP_N};
         pr_sync   <= {pr_sync[1:0], PRESET_N};
      end
   end

   assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
   assign cs_rise   = cs_sync[1] & ~cs_sync[2];
   assign pr_rise   = pr_sync[1] & ~pr_sync[2];
   assign w         = dwscl_word_type'(shift);

   // shift register locked while a save is pending
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         shift <= 16'h0000;
         bits  <= 6'h00;
      end
      else if (state == DWSCL_BUSY)
      begin
         bits <= bits;
      end
      else if (!cs_sync[1] && sclk_rise)
      begin
         shift <= {shift[14:0], sdi_sync[1]};
         bits  <= bits + 6'h01;
      end
      else if (cs_rise)
      begin
         bits <= 6'h00;
      end
   end

   // the shifter's top bit is the input delayed by 16 clocks; updated on falls
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         sdo_bit <= 1'b0;
      end
      else if (cs_sync[1] || sclk_fall)
      begin
         sdo_bit <= shift[15];
      end
   end

   // a frame of a multiple of 16 bits executes its last word, a bare strobe repeats the last executed word if it was repeatable
   always_comb
   begin
      exec    = w;
      do_exec = 1'b0;
      if (cs_rise && state == DWSCL_IDLE)
      begin
         if (bits == 6'h00 && repeat_ok)
         begin
            exec    = last;
            do_exec = 1'b1;
         end
         else if (bits != 6'h00 && bits[3:0] == 4'h0)
         begin
            do_exec = 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state     <= DWSCL_POWERUP;
         busy_cnt  <= 32'h0;
         READY     <= 1'b0;
         LOW_POWER <= 1'b0;
         last      <= '0;
         repeat_ok <= 1'b0;
         wiper[0]  <= `DWSCL_MIDSCALE;
         wiper[1]  <= `DWSCL_MIDSCALE;
         for (int i = 0; i < 16; i++)
            store[i] <= `DWSCL_MIDSCALE;
      end
      else
      begin
         case (state)
            DWSCL_POWERUP:
            begin
               wiper[0] <= store[0];
               wiper[1] <= store[1];
               READY    <= 1'b1;
               state    <= DWSCL_IDLE;
            end
            DWSCL_BUSY:
            begin
               if (busy_cnt >= 32'(SAVE_CYCLES - 1))
               begin
                  READY <= 1'b1;
                  state <= DWSCL_IDLE;
               end
               busy_cnt <= busy_cnt + 32'h1;
            end
            DWSCL_IDLE:
            begin
               if (!pr_sync[1])
               begin
                  wiper[0] <= `DWSCL_MIDSCALE;
                  wiper[1] <= `DWSCL_MIDSCALE;
               end
               else if (pr_rise)
               begin
                  wiper[0] <= store[0];
                  wiper[1] <= store[1];
                  READY    <= 1'b1;
               end
               else if (do_exec)
               begin
                  LOW_POWER <= (exec.cmd == DWSCL_NOP);
                  if (bits != 6'h00)
                  begin
                     last      <= w;
                     repeat_ok <= is_repeatable(w.cmd);
                  end
                  case (dwscl_cmd_type'(exec.cmd))
                     DWSCL_LOAD:
                        if (wp_sync[1])
                           wiper[exec.adr[0]] <= exec.dat;
                     DWSCL_SAVE:
                        if (wp_sync[1])
                        begin
                           store[{3'h0, exec.adr[0]}] <= wiper[exec.adr[0]];
                           READY    <= 1'b0;
                           busy_cnt <= 32'h0;
                           state    <= DWSCL_BUSY;
                        end
                     DWSCL_SAVEDATA:
                        if (wp_sync[1])
                        begin
                           store[exec.adr] <= exec.dat;
                           READY    <= 1'b0;
                           busy_cnt <= 32'h0;
                           state    <= DWSCL_BUSY;
                        end
                     DWSCL_RESTORE1:
                        wiper[exec.adr[0]] <= store[{3'h0, exec.adr[0]}];
                     DWSCL_RESTORE:
                     begin
                        wiper[0] <= store[0];
                        wiper[1] <= store[1];
                        READY    <= 1'b1;
                     end
                     DWSCL_INC1:
                        if (wp_sync[1])
                           wiper[exec.adr[0]] <= step_up(wiper[exec.adr[0]]);
                     DWSCL_DEC1:
                        if (wp_sync[1])
                           wiper[exec.adr[0]] <= step_dn(wiper[exec.adr[0]]);
                     DWSCL_SHL1:
                        if (wp_sync[1])
                           wiper[exec.adr[0]] <= shl(wiper[exec.adr[0]]);
                     DWSCL_SHR1:
                        if (wp_sync[1])
                           wiper[exec.adr[0]] <= {1'b0, wiper[exec.adr[0]][7:1]};
                     DWSCL_INCALL, DWSCL_DECALL, DWSCL_SHLALL, DWSCL_SHRALL:
                        if (wp_sync[1])
                           for (int k = 0; k < 2; k++)
                              case (dwscl_cmd_type'(exec.cmd))
                                 DWSCL_INCALL: wiper[k] <= step_up(wiper[k]);
                                 DWSCL_DECALL: wiper[k] <= step_dn(wiper[k]);
                                 DWSCL_SHLALL: wiper[k] <= shl(wiper[k]);
                                 default:      wiper[k] <= {1'b0, wiper[k][7:1]};
                              endcase
                     default:
                        READY <= READY;
                  endcase
               end
            end
            default:
               state <= DWSCL_IDLE;
         endcase
      end
   end

   assign SDO_OUT      = 1'b0;
   assign SDO_OE_N     = cs_sync[1] | sdo_bit;
   assign FIRST_WIPER  = wiper[0];
   assign SECOND_WIPER = wiper[1];
   assign STORE0       = store[0];
   assign STORE1       = store[1];
endmodule

// ===== test/dwscl_properties.sv
// port-level assertions for the serial command logic
`timescale 1ns/1ps
module dwscl_properties
   import dwscl_pkg::*;
#(
   parameter int SAVE_CYCLES = 50
)
(
   input wire logic       CLOCK,        // system clock
   input wire logic       RESET_N,      // asynchronous reset
   input wire logic       CS_N,         // chip select
   input wire logic       PRESET_N,     // preset input
   input wire logic       SDO_OUT,      // open-drain data value
   input wire logic       SDO_OE_N,     // open-drain enable
   input wire logic       READY,        // save done
   input wire logic       LOW_POWER,    // idle state
   input wire logic [7:0] FIRST_WIPER,  // first wiper code
   input wire logic [7:0] SECOND_WIPER, // second wiper code
   input wire logic [7:0] STORE0,       // first store
   input wire logic [7:0] STORE1        // second store
);
   int unsigned low_cnt;
   logic        seen_high;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   // counts how long ready has stayed low since reset or since its last high cycle
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         low_cnt   <= 0;
         seen_high <= 1'b0;
      end
      else
      begin
         low_cnt   <= READY ? 0 : low_cnt + 1;
         seen_high <= seen_high | READY;
      end
   end
   sdo_idle_off_a : assert property (CS_N [*4] |-> SDO_OE_N)
      else $error("serial output driven while deselected");
   sdo_drive_low_a : assert property (!SDO_OUT)
      else $error("open-drain data not low");
   sel_hold_a : assert property ((!CS_N && PRESET_N) [*8] |-> $stable({FIRST_WIPER, SECOND_WIPER}))
      else $error("wiper moved inside a frame");
   ready_width_a : assert property ($rose(READY) && seen_high |->
      low_cnt >= SAVE_CYCLES - 1 && low_cnt <= SAVE_CYCLES + 1)
      else $error("save length wrong");
   ready_bound_a : assert property (low_cnt <= SAVE_CYCLES + 1)
      else $error("ready low too long");
   save_lock_a : assert property ((!READY && PRESET_N) [*3] |-> $stable({FIRST_WIPER, SECOND_WIPER}))
      else $error("wiper moved during save");
   store_write_a : assert property ($changed({STORE0, STORE1}) |-> !READY || !$past(READY))
      else $error("store written outside a save");
   preset_mid_a : assert property (!PRESET_N [*5] |-> {FIRST_WIPER, SECOND_WIPER} == 16'h8080)
      else $error("preset did not force midscale");
   lowpower_exec_a : assert property ($rose(LOW_POWER) |-> $past(CS_N, 2))
      else $error("idle state entered before deselect");
endmodule
bind dwscl_top dwscl_properties #(.SAVE_CYCLES(SAVE_CYCLES)) chk (.CLOCK, .RESET_N, .CS_N, .PRESET_N,
   .SDO_OUT, .SDO_OE_N, .READY, .LOW_POWER, .FIRST_WIPER, .SECOND_WIPER, .STORE0, .STORE1);

// ===== test/dwscl_spi_master.sv
// spi master model for the serial command port
`timescale 1ns/1ps
module dwscl_spi_master
(
   output logic        sclk,     // serial clock, low outside frames
   output logic        sdi,      // serial data to the device
   output logic        cs_n,     // chip select
   input  wire logic   sdo_line, // pulled-up serial output
   output logic [31:0] seen      // bits captured from sdo_line
);
   initial
   begin
      sclk = 1'b0;
      sdi  = 1'b0;
      cs_n = 1'b1;
      seen = 32'h0;
   end
   // mode 0: data set while clock low, taken on the rise
   task automatic frame(input logic [31:0] w, input int n);
      seen = 32'h0;
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi = w[i];
         #80 sclk = 1'b1;
         seen = {seen[30:0], sdo_line};
         #80 sclk = 1'b0;
      end
      #80 cs_n = 1'b1;
      sdi = ~sdi;
      #200;
   endtask
   task automatic strobe();
      cs_n = 1'b0;
      #80 cs_n = 1'b1;
      #200;
   endtask
endmodule

// ===== test/dwscl_top_tb.sv
// self-checking bench for the serial command logic
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module dwscl_top_tb;
   import dwscl_pkg::*;
   logic       clock, reset_n, wp_n, preset_n, sclk, sdi, cs_n, sdo_out, sdo_oe_n, ready, low_power;
   logic [7:0] first_wiper, second_wiper, store0, store1;
   int         error_cnt, num_checks;
   wire        sdo_line = sdo_oe_n ? 1'b1 : sdo_out;
   always #4 clock = ~clock;
   dwscl_top #(.SAVE_CYCLES(400)) uut (.CLOCK(clock), .RESET_N(reset_n), .SCLK(sclk), .SDI(sdi),
      .CS_N(cs_n), .WP_N(wp_n), .PRESET_N(preset_n), .SDO_OUT(sdo_out), .SDO_OE_N(sdo_oe_n),
      .READY(ready), .LOW_POWER(low_power), .FIRST_WIPER(first_wiper), .SECOND_WIPER(second_wiper),
      .STORE0(store0), .STORE1(store1));
   dwscl_spi_master mst (.sclk(sclk), .sdi(sdi), .cs_n(cs_n), .sdo_line(sdo_line), .seen());
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 1000)
      begin
         tick(1);
         n++;
      end
      if (n == 1000)
      begin
         error_cnt++;
         complete_run();
      end
   endtask
   task automatic t_load();
      mst.frame(32'hb040, 16);
      `CHK("first wiper", 8'h40, first_wiper)
      mst.frame(32'hb1ff, 16);
      `CHK("echo", 16'hb040, mst.seen[15:0])
      `CHK("second wiper", 8'hff, second_wiper)
      mst.frame(32'h2000, 16);
      `CHK("ready", 1'b0, ready)
      wait_ready();
      `CHK("store0", 8'h40, store0)
      mst.frame(32'h0000, 16);
      `CHK("low power", 1'b1, low_power)
      $display("load test done");
   endtask
   task automatic t_length();
      mst.frame(32'h0b01, 12);
      `CHK("twelve bits", 8'h40, first_wiper)
      mst.frame(32'h16033, 17);
      `CHK("seventeen bits", 8'h40, first_wiper)
      mst.frame(32'hb0ccb033, 32);
      `CHK("double word", 8'h33, first_wiper)
      $display("length test done");
   endtask
   task automatic t_repeat();
      mst.frame(32'hc000, 16);
      mst.strobe();
      `CHK("inc repeat", 8'h35, first_wiper)
      mst.frame(32'h6000, 16);
      mst.strobe();
      `CHK("dec repeat", 8'h33, first_wiper)
      mst.frame(32'h4000, 16);
      `CHK("shift right", 8'h19, first_wiper)
      mst.frame(32'he000, 16);
      `CHK("shift left", 8'h33, first_wiper)
      $display("repeat test done");
   endtask
   task automatic t_protect();
      wp_n = 1'b0;
      mst.frame(32'hb0aa, 16);
      `CHK("protected", 8'h33, first_wiper)
      mst.frame(32'h8000, 16);
      `CHK("restore", 8'h40, first_wiper)
      mst.frame(32'h0000, 16);
      wp_n = 1'b1;
      $display("protect test done");
   endtask
   task automatic t_preset();
      mst.frame(32'h3177, 16);
      wait_ready();
      `CHK("store1", 8'h77, store1)
      preset_n = 1'b0;
      tick(10);
      `CHK("preset mid", 16'h8080, {first_wiper, second_wiper})
      preset_n = 1'b1;
      tick(10);
      `CHK("preset reload", 16'h4077, {first_wiper, second_wiper})
      $display("preset test done");
   endtask
   task automatic t_lock();
      mst.frame(32'h2100, 16);
      mst.frame(32'hb1aa, 16);
      wait_ready();
      `CHK("locked", 8'h77, second_wiper)
      $display("lock test done");
   endtask
   initial
   begin
      clock = 1'b0;
      reset_n = 1'b0;
      wp_n = 1'b1;
      preset_n = 1'b1;
      error_cnt = 0;
      num_checks = 0;
      tick(5);
      reset_n = 1'b1;
      tick(8);
      `CHK("power-on", 16'h8080, {first_wiper, second_wiper})
      t_load();
      t_length();
      t_repeat();
      t_protect();
      t_preset();
      t_lock();
      complete_run();
   end
endmodule
